// ===== serial_rx_irq_defs.svh
// register offsets, field positions, reset values and timing counts of the serial channel
`ifndef SERIAL_RX_IRQ_DEFS_SVH
`define SERIAL_RX_IRQ_DEFS_SVH
`define OFS_MODE 8'h00
`define OFS_BRATE 8'h04
`define OFS_CTRL 8'h08
`define OFS_TXDATA 8'h0C
`define OFS_STATUS 8'h10
`define OFS_RXDATA 8'h14
`define OFS_PORT 8'h18
// mode register bits
`define MODE_CLOCKED 7
// control register bits
`define CTRL_TIE 7
`define CTRL_RIE 6
`define CTRL_TE 5
`define CTRL_RE 4
`define CTRL_TX_END_IRQ_ENABLE 2
`define CTRL_CLOCK_SOURCE_BIT1 1
`define CTRL_CLOCK_SOURCE_BIT0 0
// status register bits
`define ST_TX_EMPTY_FLAG 7
`define ST_RX_FULL_FLAG 6
`define ST_OVERRUN_FLAG 5
`define ST_FER 4
`define ST_PER 3
`define ST_TX_END_FLAG 2
// port register bits
`define PORT_TXD_DR 0
`define PORT_TXD_DDR 1
`define PORT_SCK_DR 2
`define PORT_SCK_DDR 3
`define RST_MODE 8'h00
`define RST_BRATE 8'hFF
`define RST_CTRL 8'h00
`define RST_TXDATA 8'hFF
`define RST_STATUS 8'h84
`define OVERSAMPLE 16
`define SAMPLE_POINT 8
`define DATA_BITS 8
`endif

// ===== serial_rx_irq_pkg.sv
// types shared by the serial channel
package serial_rx_irq_pkg;
  typedef struct packed {
    logic rx_error_irq;
    logic rx_full_irq;
    logic tx_empty_irq;
    logic tx_end_irq;
  } irq_lines_t;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SHIFT = 2'b01,
    TX_HOLD = 2'b10
  } tx_state_t;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } rx_state_t;
endpackage : serial_rx_irq_pkg

// ===== serial_rx_irq.sv
// serial channel: receive path, status flags, transmitter and interrupt lines, with axi4-lite slave
// What this block does
// - dma read of received byte clears the full flag automatically.
// - serial bits shift in least significant first, most significant last.
// - end of byte: empty holder takes data and sets full, or only framing error if stop bit low; else error.
// - any receive error blocks further transmit and receive until cleared.
// - full interrupt line high while full flag and receive interrupt enable set.
// - error line high while any error flag and receive interrupt enable set.
// - empty line high while transmit-empty flag and its enable set.
// - end line high while transmit-end flag and its enable set.
// - dma write of transmit byte clears the transmit-empty flag.
// - only full and empty requests may start a dma transfer.
// - four separate lines, fixed priority error, full, empty, end.
// - only channel zero offers its requests as dma triggers.
// - move to shift register sets empty flag; writes always accepted.
// - overrun keeps full, drops byte; framing error still transfers.
// - during break the receiver runs, framing error sets again.
// - clearing transmit enable resets transmitter; pin then follows port bits.
// - clocked mode never starts transmit while an error flag is set.
// - clearing receive enable leaves the error flags untouched.
// - async receive at sixteen times bit rate, sample on eighth tick.
// - clock pin drives low half a cycle when clocked mode clears with transmit enable and both clock source bits clear.
// - clearing transmit enable sets empty flag, initialises shift register.
// - clocked mode samples on rising serial clock, eight bit bytes.
`timescale 1ns/1ps
`include "serial_rx_irq_defs.svh"
module serial_rx_irq
  import serial_rx_irq_pkg::*;
#(
  parameter int CHANNEL = 0
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // axi4-lite write
  input wire logic [7:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // axi4-lite read
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // dma controller
  input wire logic i_dma_rx_read,
  input wire logic i_dma_tx_write,
  input wire logic [7:0] i_dma_tx_data,
  output logic [7:0] o_dma_rx_data,
  output logic o_dma_rx_req,
  output logic o_dma_tx_req,
  // serial pins
  input wire logic i_rxd,
  input wire logic i_sck,
  output logic o_txd,
  output logic o_txd_oe_n,
  output logic o_sck,
  output logic o_sck_oe_n,
  // interrupt lines
  output irq_lines_t o_irq
);
  logic [7:0] mode_r, brate_r, ctrl_r, tx_holding_reg, port_r;
  logic [7:0] rx_holding_reg, rx_shift_reg, tx_shift_reg;
  logic tx_empty_flag, rx_full_flag, overrun_flag, framing_err_flag, parity_err_flag, tx_end_flag;
  // pin synchronisers
  logic rxd_s1_r, rxd_r, sck_s1_r, sck_r, sck_d_r;
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      rxd_s1_r <= 1'b1;
      rxd_r <= 1'b1;
      sck_s1_r <= 1'b1;
      sck_r <= 1'b1;
      sck_d_r <= 1'b1;
    end else begin
      rxd_s1_r <= i_rxd;
      rxd_r <= rxd_s1_r;
      sck_s1_r <= i_sck;
      sck_r <= sck_s1_r;
      sck_d_r <= sck_r;
    end
  end
  wire clocked = mode_r[`MODE_CLOCKED];
  wire tx_en = ctrl_r[`CTRL_TE];
  wire rx_en = ctrl_r[`CTRL_RE];
  wire any_err = overrun_flag | framing_err_flag | parity_err_flag;
  wire ext_clk = ctrl_r[`CTRL_CLOCK_SOURCE_BIT1];
  // internal serial clock: half period is brate_r+1 system cycles, 16 ticks per bit in async
  logic [7:0] div_r;
  logic int_sck_r;
  logic tick_r;
  logic busy_clk;
  wire div_end = (div_r == brate_r);
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      div_r <= 8'h00;
      int_sck_r <= 1'b1;
      tick_r <= 1'b0;
    end else begin
      div_r <= div_end ? 8'h00 : div_r + 8'h01;
      tick_r <= div_end;
      if (div_end && busy_clk) int_sck_r <= ~int_sck_r;
      else if (!busy_clk && div_end) int_sck_r <= 1'b1;
    end
  end
  wire int_rise = div_end && busy_clk && !int_sck_r;
  wire int_fall = div_end && busy_clk && int_sck_r;
  wire sck_rise = ext_clk ? (sck_r & ~sck_d_r) : int_rise;
  wire sck_fall = ext_clk ? (~sck_r & sck_d_r) : int_fall;
  // bus slave
  logic aw_got_r, w_got_r;
  logic [7:0] aw_r;
  logic [31:0] w_r;
  logic [3:0] ws_r;
  wire aw_hs = i_awvalid & o_awready;
  wire w_hs = i_wvalid & o_wready;
  wire do_write = aw_got_r & w_got_r & ~o_bvalid;
  wire wr_ctrl = do_write & (aw_r == `OFS_CTRL) & ws_r[0];
  wire wr_mode = do_write & (aw_r == `OFS_MODE) & ws_r[0];
  wire wr_brate = do_write & (aw_r == `OFS_BRATE) & ws_r[0];
  wire wr_port = do_write & (aw_r == `OFS_PORT) & ws_r[0];
  wire wr_tx = do_write & (aw_r == `OFS_TXDATA) & ws_r[0];
  wire wr_stat = do_write & (aw_r == `OFS_STATUS) & ws_r[0];
  wire wr_known = (aw_r == `OFS_CTRL) | (aw_r == `OFS_MODE) | (aw_r == `OFS_BRATE) | (aw_r == `OFS_PORT) |
                  (aw_r == `OFS_TXDATA) | (aw_r == `OFS_STATUS) | (aw_r == `OFS_RXDATA);
  wire [7:0] wb = w_r[7:0];
  // status: software may only write zero to clear a flag
  wire clr_tx_empty_flag = wr_stat & ~wb[`ST_TX_EMPTY_FLAG];
  wire clr_rx_full_flag = wr_stat & ~wb[`ST_RX_FULL_FLAG];
  wire clr_overrun_flag = wr_stat & ~wb[`ST_OVERRUN_FLAG];
  wire clr_fer = wr_stat & ~wb[`ST_FER];
  wire clr_per = wr_stat & ~wb[`ST_PER];
  wire clr_tx_end_flag = wr_stat & ~wb[`ST_TX_END_FLAG];
  wire [7:0] status = {tx_empty_flag, rx_full_flag, overrun_flag, framing_err_flag,
                       parity_err_flag, tx_end_flag, 2'b00};
  logic [7:0] rsel;
  always_comb begin
    case (i_araddr)
      `OFS_MODE: rsel = mode_r;
      `OFS_BRATE: rsel = brate_r;
      `OFS_CTRL: rsel = ctrl_r;
      `OFS_TXDATA: rsel = tx_holding_reg;
      `OFS_STATUS: rsel = status;
      `OFS_RXDATA: rsel = rx_holding_reg;
      `OFS_PORT: rsel = port_r;
      default: rsel = 8'h00;
    endcase
  end
  wire rd_known = (i_araddr <= `OFS_PORT) && (i_araddr[1:0] == 2'b00);
  wire ar_hs = i_arvalid & o_arready;
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_r <= 8'h00;
      w_r <= 32'h0000_0000;
      ws_r <= 4'h0;
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      o_bvalid <= 1'b0;
      o_bresp <= 2'b00;
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rresp <= 2'b00;
      o_rdata <= 32'h0000_0000;
    end else begin
      if (aw_hs) begin
        aw_got_r <= 1'b1;
        aw_r <= i_awaddr;
        o_awready <= 1'b0;
      end
      if (w_hs) begin
        w_got_r <= 1'b1;
        w_r <= i_wdata;
        ws_r <= i_wstrb;
        o_wready <= 1'b0;
      end
      if (do_write) begin
        o_bvalid <= 1'b1;
        o_bresp <= wr_known ? 2'b00 : 2'b10;
      end
      if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
      if (ar_hs) begin
        o_arready <= 1'b0;
        o_rvalid <= 1'b1;
        o_rdata <= {24'h00_0000, rsel};
        o_rresp <= rd_known ? 2'b00 : 2'b10;
      end
      if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
        o_arready <= 1'b1;
      end
    end
  end
  // control registers
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      mode_r <= `RST_MODE;
      brate_r <= `RST_BRATE;
      ctrl_r <= `RST_CTRL;
      port_r <= 8'h00;
    end else begin
      if (wr_mode) mode_r <= wb;
      if (wr_brate) brate_r <= wb;
      if (wr_ctrl) ctrl_r <= wb;
      if (wr_port) port_r <= wb;
    end
  end
  // transmitter, clocked framing only
  tx_state_t tx_state_r;
  logic [2:0] tx_cnt_r;
  logic txd_r;
  wire tx_data_wr = wr_tx | i_dma_tx_write;
  wire [7:0] tx_data_in = i_dma_tx_data;
  wire tx_can_load = tx_en && !tx_empty_flag && !any_err;
  assign busy_clk = (tx_state_r == TX_SHIFT) || (rx_en && !ext_clk && !any_err && !rx_full_flag) || tx_can_load;
  logic tx_load;
  always_comb begin
    tx_load = 1'b0;
    case (tx_state_r)
      TX_IDLE, TX_HOLD: tx_load = tx_can_load && clocked;
      TX_SHIFT: tx_load = sck_fall && (tx_cnt_r == 3'd7) && tx_can_load;
      default: tx_load = 1'b0;
    endcase
  end
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      tx_state_r <= TX_IDLE;
      tx_cnt_r <= 3'd0;
      tx_shift_reg <= 8'hFF;
      txd_r <= 1'b1;
    end else if (!tx_en) begin
      tx_state_r <= TX_IDLE;
      tx_cnt_r <= 3'd0;
      tx_shift_reg <= 8'hFF;
      txd_r <= 1'b1;
    end else begin
      case (tx_state_r)
        TX_IDLE, TX_HOLD: begin
          if (tx_load) begin
            tx_shift_reg <= tx_holding_reg;
            tx_cnt_r <= 3'd0;
            tx_state_r <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (sck_fall) begin
            txd_r <= tx_shift_reg[tx_cnt_r];
            if (tx_cnt_r == 3'd7) begin
              if (tx_load) begin
                tx_shift_reg <= tx_holding_reg;
                tx_cnt_r <= 3'd0;
              end else begin
                tx_state_r <= TX_HOLD;
              end
            end else begin
              tx_cnt_r <= tx_cnt_r + 3'd1;
            end
          end
        end
        default: tx_state_r <= TX_IDLE;
      endcase
    end
  end
  wire tx_last_done = (tx_state_r == TX_SHIFT) && sck_fall && (tx_cnt_r == 3'd7) && !tx_can_load;
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      tx_holding_reg <= `RST_TXDATA;
      tx_empty_flag <= 1'b1;
      tx_end_flag <= 1'b1;
    end else begin
      if (tx_data_wr) tx_holding_reg <= wr_tx ? wb : tx_data_in;
      // set wins over clear
      if (!tx_en || tx_load) tx_empty_flag <= 1'b1;
      else if (clr_tx_empty_flag || (i_dma_tx_write && CHANNEL == 0)) tx_empty_flag <= 1'b0;
      if (!tx_en || tx_last_done) tx_end_flag <= 1'b1;
      else if (clr_tx_end_flag || tx_load) tx_end_flag <= 1'b0;
    end
  end
  // receiver
  rx_state_t rx_state_r;
  logic [2:0] rx_cnt_r;
  logic [3:0] os_r;
  logic rx_par_r;
  wire rx_ok = rx_en && !any_err;
  wire os_tick = tick_r && !clocked;
  wire os_mid = os_tick && (os_r == 4'(`SAMPLE_POINT - 1));
  wire rx_bit = clocked ? sck_rise : os_mid;
  logic rx_done, rx_ferr;
  assign rx_done = clocked ? (rx_state_r == RX_DATA && rx_bit && rx_cnt_r == 3'd7)
                           : (rx_state_r == RX_STOP && os_mid);
  assign rx_ferr = !clocked && !rxd_r;
  wire [7:0] rx_byte = {rxd_r, rx_shift_reg[7:1]};
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      rx_state_r <= RX_IDLE;
      rx_cnt_r <= 3'd0;
      os_r <= 4'h0;
      rx_shift_reg <= 8'h00;
      rx_par_r <= 1'b0;
    end else if (!rx_ok) begin
      rx_state_r <= RX_IDLE;
      rx_cnt_r <= 3'd0;
      os_r <= 4'h0;
    end else begin
      if (os_tick) os_r <= os_r + 4'h1;
      case (rx_state_r)
        RX_IDLE: begin
          if (clocked) rx_state_r <= RX_DATA;
          else if (!rxd_r) begin
            os_r <= 4'h0;
            rx_state_r <= RX_START;
          end
        end
        RX_START: if (os_mid) rx_state_r <= rxd_r ? RX_IDLE : RX_DATA;
        RX_DATA: begin
          if (rx_bit) begin
            rx_shift_reg <= rx_byte;
            rx_par_r <= rx_par_r ^ rxd_r;
            rx_cnt_r <= rx_cnt_r + 3'd1;
            if (rx_cnt_r == 3'd7) rx_state_r <= clocked ? RX_DATA : RX_STOP;
          end
        end
        RX_STOP: if (os_mid) rx_state_r <= RX_IDLE;
        default: rx_state_r <= RX_IDLE;
      endcase
    end
  end
  wire [7:0] rx_final = clocked ? rx_byte : rx_shift_reg;
  wire rx_take = rx_ok && rx_done && !rx_full_flag;
  wire rx_over = rx_ok && rx_done && rx_full_flag;
  wire dma_rd = i_dma_rx_read && (CHANNEL == 0);
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      rx_holding_reg <= 8'h00;
      rx_full_flag <= 1'b0;
      overrun_flag <= 1'b0;
      framing_err_flag <= 1'b0;
      parity_err_flag <= 1'b0;
    end else begin
      if (rx_take) rx_holding_reg <= rx_final;
      if (rx_take && !rx_ferr) rx_full_flag <= 1'b1;
      else if (clr_rx_full_flag || dma_rd) rx_full_flag <= 1'b0;
      if (rx_over) overrun_flag <= 1'b1;
      else if (clr_overrun_flag) overrun_flag <= 1'b0;
      if (rx_take && rx_ferr) framing_err_flag <= 1'b1;
      else if (clr_fer) framing_err_flag <= 1'b0;
      if (clr_per) parity_err_flag <= 1'b0;
    end
  end
  // clock pin: low hold for half a serial clock when clocked mode clears with transmit enable and both clock source bits clear
  logic sck_glitch_r;
  logic clocked_d_r;
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      sck_glitch_r <= 1'b0;
      clocked_d_r <= 1'b0;
    end else begin
      clocked_d_r <= clocked;
      if (clocked_d_r && !clocked && !tx_en && !ext_clk && !ctrl_r[`CTRL_CLOCK_SOURCE_BIT0]) sck_glitch_r <= 1'b1;
      else if (div_end) sck_glitch_r <= 1'b0;
    end
  end
  wire sck_drive_int = clocked && !ext_clk;
  // outputs, all registered; interrupt lines are plain levels
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_irq <= '0;
      o_dma_rx_req <= 1'b0;
      o_dma_tx_req <= 1'b0;
      o_dma_rx_data <= 8'h00;
      o_txd <= 1'b1;
      o_txd_oe_n <= 1'b1;
      o_sck <= 1'b1;
      o_sck_oe_n <= 1'b1;
    end else begin
      o_irq.rx_error_irq <= any_err && ctrl_r[`CTRL_RIE];
      o_irq.rx_full_irq <= rx_full_flag && ctrl_r[`CTRL_RIE];
      o_irq.tx_empty_irq <= tx_empty_flag && ctrl_r[`CTRL_TIE];
      o_irq.tx_end_irq <= tx_end_flag && ctrl_r[`CTRL_TX_END_IRQ_ENABLE];
      o_dma_rx_req <= (CHANNEL == 0) && rx_full_flag && ctrl_r[`CTRL_RIE] && !dma_rd;
      o_dma_tx_req <= (CHANNEL == 0) && tx_empty_flag && ctrl_r[`CTRL_TIE] && tx_en && !i_dma_tx_write;
      o_dma_rx_data <= rx_holding_reg;
      o_txd <= tx_en ? txd_r : port_r[`PORT_TXD_DR];
      o_txd_oe_n <= tx_en ? 1'b0 : ~port_r[`PORT_TXD_DDR];
      if (sck_glitch_r) begin
        o_sck <= 1'b0;
        o_sck_oe_n <= 1'b0;
      end else if (sck_drive_int) begin
        o_sck <= int_sck_r;
        o_sck_oe_n <= 1'b0;
      end else begin
        o_sck <= port_r[`PORT_SCK_DR];
        o_sck_oe_n <= ~port_r[`PORT_SCK_DDR];
      end
    end
  end
endmodule : serial_rx_irq

// ===== serial_rx_irq_checker.sv
// assertions on the serial channel ports: bus handshake, dma triggers, interrupt levels
`timescale 1ns/1ps
module serial_rx_irq_checker
  import serial_rx_irq_pkg::*;
#(
  parameter int CHANNEL = 0
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // bus
  input wire logic o_awready,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic i_bready,
  input wire logic [7:0] i_araddr,
  input wire logic i_arvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic [1:0] o_rresp,
  input wire logic o_rvalid,
  input wire logic i_rready,
  // dma and interrupts
  input wire logic i_dma_rx_read,
  input wire logic o_dma_rx_req,
  input wire logic o_dma_tx_req,
  input irq_lines_t o_irq
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);
  a_dma_chan_only: assert property (o_dma_rx_req || o_dma_tx_req |-> CHANNEL == 0)
    else $error("dma request from a nonzero channel");
  a_rx_req_irq: assert property (o_dma_rx_req |-> o_irq.rx_full_irq)
    else $error("rx dma request without full request");
  a_tx_req_irq: assert property (o_dma_tx_req |-> o_irq.tx_empty_irq)
    else $error("tx dma request without empty request");
  a_dma_read_clr: assert property (i_dma_rx_read && o_dma_rx_req |-> ##[1:3] !o_dma_rx_req)
    else $error("dma read left the full request up");
  // full request may only drop after a register write or a dma read
  a_full_fall_cause: assert property ($fell(o_irq.rx_full_irq) |->
    $past(o_bvalid) || $past(o_bvalid, 2) || $past(i_dma_rx_read, 2) || $past(i_dma_rx_read, 3))
    else $error("full request dropped without cause");
  a_bvalid_hold: assert property (o_bvalid && !i_bready |=> o_bvalid)
    else $error("write response withdrawn");
  a_rvalid_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read response withdrawn or changed");
  a_busy_no_ready: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write readies up during response");
  a_unmapped_err: assert property (i_arvalid && o_arready && i_araddr > 8'h18 |=>
    o_rvalid && o_rresp == 2'h2 && o_rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  c_full: cover property ($rose(o_irq.rx_full_irq));
  c_error: cover property ($rose(o_irq.rx_error_irq));
  c_dma_read: cover property (i_dma_rx_read && o_dma_rx_req);
endmodule : serial_rx_irq_checker

// ===== serial_peer.sv
// serial peer: sends clocked-mode bytes on the data and clock pins
`timescale 1ns/1ps
module serial_peer (
  // serial pins
  input wire logic i_txd,
  output logic o_rxd,
  output logic o_sck
);
  // transmit byte seen on the data-out pin, sampled at each rising clock
  logic [7:0] txd_seen;
  initial begin
    o_rxd = 1'b1;
    o_sck = 1'b1;
  end
  // data moves on the falling clock, steady at the rise; clock idles high
  task send_byte(input logic [7:0] b);
    // step off the system clock edge so no pin moves on a sampling edge
    #1;
    for (int i = 0; i < 8; i++) begin
      o_sck = 1'b0;
      o_rxd = b[i];
      #40;
      txd_seen[i] = i_txd;
      o_sck = 1'b1;
      #40;
    end
    // line released with no pull: show the inverse, not the last bit
    o_rxd = ~b[7];
  endtask : send_byte
endmodule : serial_peer

// ===== test_serial_rx_irq.sv
// self-checking bench of the serial channel
`timescale 1ns/1ps
`include "serial_rx_irq_defs.svh"
module test_serial_rx_irq;
  import serial_rx_irq_pkg::*;
  logic i_clock, i_reset, i_rxd, i_sck;
  logic [7:0] i_awaddr, i_araddr, i_dma_tx_data, o_dma_rx_data;
  logic [31:0] i_wdata, o_rdata, rd;
  logic [3:0] i_wstrb;
  logic [1:0] o_bresp, o_rresp, rr, br;
  logic i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_dma_rx_read, i_dma_tx_write;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_dma_rx_req, o_dma_tx_req;
  logic o_txd, o_txd_oe_n, o_sck, o_sck_oe_n;
  irq_lines_t o_irq;
  int err_total, comparisons, cycles, sck_low_count;
  serial_rx_irq #(.CHANNEL(0)) serial_rx_irq_i (
    .i_clock, .i_reset, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready,
    .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid,
    .i_rready, .i_dma_rx_read, .i_dma_tx_write, .i_dma_tx_data, .o_dma_rx_data, .o_dma_rx_req,
    .o_dma_tx_req, .i_rxd, .i_sck, .o_txd, .o_txd_oe_n, .o_sck, .o_sck_oe_n, .o_irq
  );
  serial_peer serial_peer_i (.i_txd(o_txd), .o_rxd(i_rxd), .o_sck(i_sck));
  // counts cycles with the clock pin low, to catch a switchover glitch
  always @(posedge i_clock) begin
    if (o_sck === 1'b0) sck_low_count <= sck_low_count + 1;
  end
  initial i_clock = 1'b0;
  always #2.5 i_clock = ~i_clock;
  task end_of_test();
    if (err_total == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_total++;
      $display("Error at %0t: timeout", $time);
      end_of_test();
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task axi_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    do begin
      @(posedge i_clock);
      if (i_awvalid && o_awready) i_awvalid <= 1'b0;
      if (i_wvalid && o_wready) i_wvalid <= 1'b0;
      br = o_bresp;
    end while (!o_bvalid);
    i_bready <= 1'b0;
  endtask : axi_write
  task axi_read(input logic [7:0] a);
    @(posedge i_clock);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do begin
      @(posedge i_clock);
      if (i_arvalid && o_arready) i_arvalid <= 1'b0;
      rd = o_rdata;
      rr = o_rresp;
    end while (!o_rvalid);
    i_rready <= 1'b0;
  endtask : axi_read
  task read_check(input logic [7:0] a, input logic [31:0] exp);
    axi_read(a);
    check(rd, exp);
  endtask : read_check
  task rx_frame(input logic [7:0] b);
    serial_peer_i.send_byte(b);
    repeat (20) @(posedge i_clock);
  endtask : rx_frame
  task test_reset_values();
    read_check(`OFS_STATUS, 32'h0000_0084);
    read_check(`OFS_CTRL, 32'h0000_0000);
    check(o_irq, 32'h0000_0000);
    axi_read(8'h40);
    check(rr, 32'h0000_0002);
    check(rd, 32'h0000_0000);
    axi_write(8'h40, 32'h0000_0000);
    check(br, 32'h0000_0002);
  endtask : test_reset_values
  task test_receive();
    axi_write(`OFS_MODE, 32'h0000_0080);
    axi_write(`OFS_CTRL, 32'h0000_0052);
    rx_frame(8'h1E);
    check(o_irq, 32'h0000_0004);
    read_check(`OFS_STATUS, 32'h0000_00C4);
    read_check(`OFS_RXDATA, 32'h0000_001E);
    axi_write(`OFS_STATUS, 32'h0000_00BF);
    repeat (3) @(posedge i_clock);
    check(o_irq, 32'h0000_0000);
  endtask : test_receive
  task test_overrun();
    rx_frame(8'h61);
    rx_frame(8'h5A);
    check(o_irq, 32'h0000_000C);
    read_check(`OFS_STATUS, 32'h0000_00E4);
    read_check(`OFS_RXDATA, 32'h0000_0061);
    axi_write(`OFS_CTRL, 32'h0000_0042);
    read_check(`OFS_STATUS, 32'h0000_00E4);
    axi_write(`OFS_CTRL, 32'h0000_0052);
    axi_write(`OFS_STATUS, 32'h0000_00BF);
    rx_frame(8'h33);
    read_check(`OFS_STATUS, 32'h0000_00A4);
    check(o_irq, 32'h0000_0008);
    axi_write(`OFS_STATUS, 32'h0000_00DF);
    rx_frame(8'hC8);
    read_check(`OFS_RXDATA, 32'h0000_00C8);
    axi_write(`OFS_STATUS, 32'h0000_00BF);
  endtask : test_overrun
  task test_dma();
    rx_frame(8'h96);
    check(o_dma_rx_req, 32'h0000_0001);
    @(posedge i_clock);
    i_dma_rx_read <= 1'b1;
    @(posedge i_clock);
    i_dma_rx_read <= 1'b0;
    repeat (3) @(posedge i_clock);
    check(o_dma_rx_data, 32'h0000_0096);
    check(o_dma_rx_req, 32'h0000_0000);
    read_check(`OFS_STATUS, 32'h0000_0084);
  endtask : test_dma
  task test_tx_irq();
    axi_write(`OFS_CTRL, 32'h0000_00A4);
    repeat (3) @(posedge i_clock);
    check(o_irq, 32'h0000_0003);
    check(o_dma_tx_req, 32'h0000_0001);
    axi_write(`OFS_CTRL, 32'h0000_0024);
    repeat (3) @(posedge i_clock);
    check(o_irq, 32'h0000_0001);
    check(o_dma_tx_req, 32'h0000_0000);
    axi_write(`OFS_CTRL, 32'h0000_0000);
    repeat (3) @(posedge i_clock);
    check(o_irq, 32'h0000_0000);
  endtask : test_tx_irq
  task dma_tx_byte(input logic [7:0] b);
    @(posedge i_clock);
    i_dma_tx_data <= b;
    i_dma_tx_write <= 1'b1;
    @(posedge i_clock);
    i_dma_tx_write <= 1'b0;
  endtask : dma_tx_byte
  task test_dma_transmit();
    axi_write(`OFS_BRATE, 32'h0000_0003);
    axi_write(`OFS_PORT, 32'h0000_000E);
    axi_write(`OFS_CTRL, 32'h0000_0022);
    read_check(`OFS_STATUS, 32'h0000_0084);
    check(o_txd, 32'h0000_0001);
    check(o_txd_oe_n, 32'h0000_0000);
    dma_tx_byte(8'hA5);
    repeat (3) @(posedge i_clock);
    read_check(`OFS_STATUS, 32'h0000_0080);
    dma_tx_byte(8'h3C);
    read_check(`OFS_STATUS, 32'h0000_0000);
    repeat (5) @(posedge i_clock);
    serial_peer_i.send_byte(8'hFF);
    check(serial_peer_i.txd_seen, 32'h0000_00A5);
    serial_peer_i.send_byte(8'hFF);
    check(serial_peer_i.txd_seen, 32'h0000_003C);
    repeat (10) @(posedge i_clock);
    read_check(`OFS_STATUS, 32'h0000_0084);
    axi_write(`OFS_CTRL, 32'h0000_0002);
    repeat (3) @(posedge i_clock);
    check(o_txd, 32'h0000_0000);
  endtask : test_dma_transmit
  task test_sck_switch();
    int base;
    axi_write(`OFS_PORT, 32'h0000_000F);
    axi_write(`OFS_CTRL, 32'h0000_0020);
    repeat (10) @(posedge i_clock);
    base = sck_low_count;
    axi_write(`OFS_CTRL, 32'h0000_0000);
    axi_write(`OFS_CTRL, 32'h0000_0002);
    axi_write(`OFS_MODE, 32'h0000_0000);
    axi_write(`OFS_CTRL, 32'h0000_0000);
    repeat (10) @(posedge i_clock);
    check(sck_low_count - base, 32'h0000_0000);
    axi_write(`OFS_MODE, 32'h0000_0080);
    axi_write(`OFS_CTRL, 32'h0000_0020);
    repeat (10) @(posedge i_clock);
    base = sck_low_count;
    axi_write(`OFS_CTRL, 32'h0000_0000);
    axi_write(`OFS_MODE, 32'h0000_0000);
    repeat (10) @(posedge i_clock);
    check({31'h0, sck_low_count != base}, 32'h0000_0001);
  endtask : test_sck_switch
  initial begin
    {i_awaddr, i_araddr, i_wdata, i_dma_tx_data} = '0;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_dma_rx_read, i_dma_tx_write} = '0;
    i_wstrb = 4'h1;
    err_total = 0;
    comparisons = 0;
    i_reset = 1'b1;
    repeat (10) @(posedge i_clock);
    i_reset <= 1'b0;
    test_reset_values();
    test_receive();
    test_overrun();
    test_dma();
    test_tx_irq();
    test_dma_transmit();
    test_sck_switch();
    end_of_test();
  end
endmodule : test_serial_rx_irq
bind serial_rx_irq serial_rx_irq_checker #(.CHANNEL(CHANNEL)) serial_rx_irq_checker_i (
  .i_clock, .i_reset, .o_awready, .o_wready, .o_bvalid, .i_bready, .i_araddr, .i_arvalid, .o_arready,
  .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_dma_rx_read, .o_dma_rx_req, .o_dma_tx_req, .o_irq
);
